// ---- rtl/cstat_readout.sv ----
// channel-status decoder and loop-lock status register bank on AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
`include "cstat_defs.svh"

module cstat_readout (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // captured channel status and loop flags (asynchronous)
  input wire logic [23:0] statusBits,
  input wire logic loopLockedIn,
  input wire logic oscTimeoutIn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt
  output logic irq
);

  function automatic logic [3:0] decodeCategory(input logic [7:0] c);
    logic [3:0] r;
    r = `CSTAT_CAT_RSVD;
    unique case (c[7:5])
      3'h4: r = `CSTAT_CAT_LASER;
      3'h2: r = `CSTAT_CAT_DIGCONV;
      3'h6: r = `CSTAT_CAT_MAGNETIC;
      3'h1: r = `CSTAT_CAT_BCVIDEO;
      3'h3: r = c[4] ? `CSTAT_CAT_BCNOVID : (c[3] ? `CSTAT_CAT_ADCCP : `CSTAT_CAT_ADCNOCP);
      3'h5: r = `CSTAT_CAT_MUSIC;
      3'h7: r = `CSTAT_CAT_RSVD;
      3'h0: begin
        if (c[4]) begin
          r = `CSTAT_CAT_SOLID;
        end else if (c[3:0] == 4'h0) begin
          r = `CSTAT_CAT_GENERAL;
        end else if (c[3:1] == 3'h1) begin
          // the last bit is the generation flag, so both of its values are experimental
          r = `CSTAT_CAT_EXPER;
        end else begin
          r = `CSTAT_CAT_RSVD;
        end
      end
    endcase
    return r;
  endfunction

  function automatic logic [2:0] decodeSampling(input logic [2:0] s, input logic npcm);
    logic [2:0] r;
    if (npcm) begin
      r = (s == 3'h0) ? `CSTAT_SMP_NPCMDEF : `CSTAT_SMP_RSVD;
    end else if (s == 3'h0) begin
      r = `CSTAT_SMP_NOEMPH;
    end else if (s == 3'h1) begin
      r = `CSTAT_SMP_EMPH5015;
    end else if (s[2:1] == 2'h1) begin
      r = `CSTAT_SMP_RSVEMPH;
    end else begin
      r = `CSTAT_SMP_RSVD;
    end
    return r;
  endfunction

  // three-stage synchronisers; a change counts when stages two and three agree
  logic [23:0] statSync1_ff, statSync2_ff, statSync3_ff;
  logic [1:0] flagSync1_ff, flagSync2_ff, flagSync3_ff;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      statSync1_ff <= 24'h00_0000;
      statSync2_ff <= 24'h00_0000;
      statSync3_ff <= 24'h00_0000;
      flagSync1_ff <= 2'h0;
      flagSync2_ff <= 2'h0;
      flagSync3_ff <= 2'h0;
    end else begin
      statSync1_ff <= statusBits;
      statSync2_ff <= statSync1_ff;
      statSync3_ff <= statSync2_ff;
      flagSync1_ff <= {loopLockedIn, oscTimeoutIn};
      flagSync2_ff <= flagSync1_ff;
      flagSync3_ff <= flagSync2_ff;
    end
  end

  // held values update only once stages agree, filtering mid-change words
  cstat_pkg::cstat_fields_t fields_ff;
  logic lockFlag_ff, tmoFlag_ff;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fields_ff <= '0;
      lockFlag_ff <= 1'b0;
      tmoFlag_ff <= 1'b0;
    end else begin
      if (statSync2_ff == statSync3_ff) begin
        fields_ff.channelNumberField <= statSync3_ff[23:20];
        fields_ff.sourceNumberField <= statSync3_ff[19:16];
        fields_ff.categoryCodeField <= statSync3_ff[15:8];
        fields_ff.statusModeField <= statSync3_ff[7:6];
        fields_ff.samplingEmphasisField <= statSync3_ff[5:3];
        fields_ff.nonPcmFlag <= statSync3_ff[1];
      end
      if (flagSync2_ff[1] == flagSync3_ff[1]) begin
        lockFlag_ff <= flagSync3_ff[1];
      end
      if (flagSync2_ff[0] == flagSync3_ff[0]) begin
        tmoFlag_ff <= flagSync3_ff[0];
      end
    end
  end

  cstat_pkg::cstat_decode_t decoded;
  always_comb begin
    decoded.category = decodeCategory(fields_ff.categoryCodeField);
    decoded.sampling = decodeSampling(fields_ff.samplingEmphasisField, fields_ff.nonPcmFlag);
    decoded.modeValid = (fields_ff.statusModeField == 2'h0);
    // channel A=1 .. O=15, zero unspecified
    decoded.channelIndex = {1'b0, fields_ff.channelNumberField};
    decoded.sourceIndex = fields_ff.sourceNumberField;
  end

  logic [1:0] loopState;
  always_comb begin
    if (tmoFlag_ff) begin
      loopState = `CSTAT_LOOP_TMO;
    end else if (lockFlag_ff) begin
      loopState = `CSTAT_LOOP_LOCKED;
    end else begin
      loopState = `CSTAT_LOOP_OUT;
    end
  end

  logic [15:0] loopReg;
  always_comb begin
    loopReg = 16'h0000;
    loopReg[`CSTAT_LOCK_BIT] = lockFlag_ff;
    loopReg[`CSTAT_TMO_BIT] = tmoFlag_ff;
  end

  // interrupt events: lock change, timeout rise, channel status change
  logic prevLock_ff, prevTmo_ff;
  cstat_pkg::cstat_fields_t prevFields_ff;
  logic [`CSTAT_IRQ_W-1:0] irqStat_ff, irqEn_ff, irqEvent, irqClr;
  always_comb begin
    irqEvent = '0;
    irqEvent[`CSTAT_IRQ_LOCKCHG] = (loopState == `CSTAT_LOOP_LOCKED) != prevLock_ff;
    irqEvent[`CSTAT_IRQ_TMO] = tmoFlag_ff & ~prevTmo_ff;
    irqEvent[`CSTAT_IRQ_CSCHG] = fields_ff != prevFields_ff;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prevLock_ff <= 1'b0;
      prevTmo_ff <= 1'b0;
      prevFields_ff <= '0;
    end else begin
      prevLock_ff <= (loopState == `CSTAT_LOOP_LOCKED);
      prevTmo_ff <= tmoFlag_ff;
      prevFields_ff <= fields_ff;
    end
  end

  // axi write path: address and data taken in either order
  logic awHeld_ff, wHeld_ff;
  logic [7:0] awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic doWrite;
  assign doWrite = awHeld_ff & wHeld_ff & ~s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      awAddr_ff <= 8'h00;
      wData_ff <= 32'h0000_0000;
      wStrb_ff <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CSTAT_AXI_OKAY;
    end else begin
      s_axi_awready <= ~awHeld_ff & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~wHeld_ff & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid & s_axi_awready) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // writes to the read-only registers are ignored but answered okay
        unique case ({awAddr_ff[7:2], 2'b00})
          `CSTAT_OFS_LOOP, `CSTAT_OFS_CSLO, `CSTAT_OFS_DECODE, `CSTAT_OFS_IRQSTAT,
          `CSTAT_OFS_IRQEN, `CSTAT_OFS_IRQCLR: s_axi_bresp <= `CSTAT_AXI_OKAY;
          default: s_axi_bresp <= `CSTAT_AXI_SLVERR;
        endcase
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wrEn, wrClr;
  assign wrEn = doWrite & ({awAddr_ff[7:2], 2'b00} == `CSTAT_OFS_IRQEN) & wStrb_ff[0];
  assign wrClr = doWrite & ({awAddr_ff[7:2], 2'b00} == `CSTAT_OFS_IRQCLR) & wStrb_ff[0];
  assign irqClr = wrClr ? wData_ff[`CSTAT_IRQ_W-1:0] : '0;

  // set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irqStat_ff <= '0;
      irqEn_ff <= '0;
      irq <= 1'b0;
    end else begin
      irqStat_ff <= (irqStat_ff & ~irqClr) | irqEvent;
      if (wrEn) begin
        irqEn_ff <= wData_ff[`CSTAT_IRQ_W-1:0];
      end
      irq <= |(((irqStat_ff & ~irqClr) | irqEvent) & (wrEn ? wData_ff[`CSTAT_IRQ_W-1:0] : irqEn_ff));
    end
  end

  // axi read path, one cycle from address to data
  logic [31:0] readMux;
  always_comb begin
    unique case ({s_axi_araddr[7:2], 2'b00})
      `CSTAT_OFS_LOOP: readMux = {16'h0000, loopReg};
      `CSTAT_OFS_CSLO: readMux = {8'h00, fields_ff.channelNumberField, fields_ff.sourceNumberField,
        fields_ff.categoryCodeField, fields_ff.statusModeField, fields_ff.samplingEmphasisField,
        1'b0, fields_ff.nonPcmFlag, 1'b0};
      `CSTAT_OFS_DECODE: readMux = {13'h0000, loopState, decoded.sourceIndex, decoded.channelIndex,
        decoded.modeValid, decoded.sampling, decoded.category};
      `CSTAT_OFS_IRQSTAT: readMux = {29'h0000_0000, irqStat_ff};
      `CSTAT_OFS_IRQEN: readMux = {29'h0000_0000, irqEn_ff};
      default: readMux = 32'h0000_0000;
    endcase
  end

  logic rdOk;
  always_comb begin
    unique case ({s_axi_araddr[7:2], 2'b00})
      `CSTAT_OFS_LOOP, `CSTAT_OFS_CSLO, `CSTAT_OFS_DECODE, `CSTAT_OFS_IRQSTAT,
      `CSTAT_OFS_IRQEN, `CSTAT_OFS_IRQCLR: rdOk = 1'b1;
      default: rdOk = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CSTAT_AXI_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= readMux;
        s_axi_rresp <= rdOk ? `CSTAT_AXI_OKAY : `CSTAT_AXI_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // cstat_readout
`default_nettype wire

// ---- rtl/cstat_defs.svh ----
// constants for the channel-status and loop-lock readout block
`ifndef CSTAT_DEFS_SVH
`define CSTAT_DEFS_SVH
// register byte offsets
`define CSTAT_OFS_LOOP     8'h68
`define CSTAT_OFS_CSLO     8'h00
`define CSTAT_OFS_DECODE   8'h04
`define CSTAT_OFS_IRQSTAT  8'h08
`define CSTAT_OFS_IRQEN    8'h0C
`define CSTAT_OFS_IRQCLR   8'h10
// loop status register fields
`define CSTAT_LOCK_BIT     8
`define CSTAT_TMO_BIT      4
// category classes
`define CSTAT_CAT_GENERAL  4'h0
`define CSTAT_CAT_LASER    4'h1
`define CSTAT_CAT_DIGCONV  4'h2
`define CSTAT_CAT_MAGNETIC 4'h3
`define CSTAT_CAT_BCVIDEO  4'h4
`define CSTAT_CAT_BCNOVID  4'h5
`define CSTAT_CAT_MUSIC    4'h6
`define CSTAT_CAT_ADCNOCP  4'h7
`define CSTAT_CAT_ADCCP    4'h8
`define CSTAT_CAT_SOLID    4'h9
`define CSTAT_CAT_EXPER    4'hA
`define CSTAT_CAT_RSVD     4'hF
// sampling classes
`define CSTAT_SMP_NOEMPH   3'h0
`define CSTAT_SMP_EMPH5015 3'h1
`define CSTAT_SMP_RSVEMPH  3'h2
`define CSTAT_SMP_NPCMDEF  3'h3
`define CSTAT_SMP_RSVD     3'h7
// loop states
`define CSTAT_LOOP_OUT     2'h0
`define CSTAT_LOOP_LOCKED  2'h1
`define CSTAT_LOOP_TMO     2'h2
// interrupt bits and axi response codes
`define CSTAT_IRQ_LOCKCHG  0
`define CSTAT_IRQ_TMO      1
`define CSTAT_IRQ_CSCHG    2
`define CSTAT_IRQ_W        3
`define CSTAT_AXI_OKAY     2'h0
`define CSTAT_AXI_SLVERR   2'h2
`endif

// ---- rtl/cstat_pkg.sv ----
// types for the channel-status and loop-lock readout block
package cstat_pkg;
  typedef struct packed {
    logic [3:0] channelNumberField;
    logic [3:0] sourceNumberField;
    logic [7:0] categoryCodeField;
    logic [1:0] statusModeField;
    logic [2:0] samplingEmphasisField;
    logic nonPcmFlag;
  } cstat_fields_t;
  typedef struct packed {
    logic [3:0] category;
    logic [2:0] sampling;
    logic modeValid;
    logic [4:0] channelIndex;
    logic [3:0] sourceIndex;
  } cstat_decode_t;
endpackage

// ---- verif/cstat_readout_checker.sv ----
// assertion checker for the channel-status readout block
`timescale 1ns/1ps
`default_nettype none
`include "cstat_defs.svh"
module cstat_readout_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // watched inputs
  input wire logic [23:0] statusBits,
  input wire logic loopLockedIn,
  input wire logic oscTimeoutIn,
  // bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [7:0] rdAddr_ff;
  logic [25:0] prevIn_ff;
  logic [3:0] calm_ff;
  wire [25:0] curIn = {statusBits, loopLockedIn, oscTimeoutIn};
  // inputs cross a synchroniser, so only judge reads taken well after they settled
  // data are captured on the edge that raises rvalid and need four edges through the synchroniser
  wire rdLoop = s_axi_rvalid && rdAddr_ff == `CSTAT_OFS_LOOP && calm_ff > 4'h5;
  wire rdDec = s_axi_rvalid && rdAddr_ff == `CSTAT_OFS_DECODE && calm_ff > 4'h5;
  always_ff @(posedge clk) begin
    if (!rst_b) rdAddr_ff <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready) rdAddr_ff <= s_axi_araddr;
  end
  always_ff @(posedge clk) begin
    prevIn_ff <= curIn;
    if (!rst_b || curIn != prevIn_ff) calm_ff <= 4'h0;
    else if (calm_ff != 4'hF) calm_ff <= calm_ff + 4'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_rsvd; s_axi_rvalid && rdAddr_ff == `CSTAT_OFS_LOOP |-> (s_axi_rdata & 32'hFFFF_FEEF) == 32'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("loop register spare bits set");
  property p_lock; rdLoop |-> s_axi_rdata[8] == loopLockedIn; endproperty
  a_lock: assert property (p_lock) else $error("lock bit wrong");
  property p_tmo; rdLoop |-> s_axi_rdata[4] == oscTimeoutIn; endproperty
  a_tmo: assert property (p_tmo) else $error("timeout bit wrong");
  property p_state; rdDec |-> s_axi_rdata[18:17] == (oscTimeoutIn ? 2'h2 : {1'b0, loopLockedIn}); endproperty
  a_state: assert property (p_state) else $error("loop state wrong");
  property p_chan; rdDec |-> s_axi_rdata[12:8] == {1'b0, statusBits[23:20]}; endproperty
  a_chan: assert property (p_chan) else $error("channel wrong");
  property p_src; rdDec |-> s_axi_rdata[16:13] == statusBits[19:16]; endproperty
  a_src: assert property (p_src) else $error("source wrong");
  property p_mode; rdDec |-> s_axi_rdata[7] == (statusBits[7:6] == 2'h0); endproperty
  a_mode: assert property (p_mode) else $error("mode flag wrong");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  // both halves held at the first edge, response raised at the next
  property p_bans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid |=> ##1 s_axi_bvalid;
  endproperty
  a_bans: assert property (p_bans) else $error("write response late");
  c_tmo: cover property (rdLoop && s_axi_rdata[4]);
  c_lock: cover property (rdLoop && s_axi_rdata[8] && !s_axi_rdata[4]);
  c_dec: cover property (rdDec && s_axi_rdata[7]);
endmodule // cstat_readout_checker
bind cstat_readout cstat_readout_checker cstat_readout_checker_i (.*);
`default_nettype wire

// ---- verif/cstat_readout_bench.sv ----
// self-checking bench for the channel-status readout block
`timescale 1ns/1ps
`default_nettype none
`include "cstat_defs.svh"
module cstat_readout_bench;
  logic clk, rst_b, loopLockedIn, oscTimeoutIn, irq;
  logic [23:0] statusBits;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int errCount, checked;
  cstat_readout cstat_readout_i (.clk, .rst_b, .statusBits, .loopLockedIn, .oscTimeoutIn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errCount++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aDone, wDone;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    aDone = 1'b0;
    wDone = 1'b0;
    while (!(aDone && wDone)) begin
      @(posedge clk);
      aDone = aDone || s_axi_awready;
      wDone = wDone || s_axi_wready;
      s_axi_awvalid <= !aDone;
      s_axi_wvalid <= !wDone;
    end
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  function automatic logic [3:0] catOf(input logic [7:0] c);
    casez (c)
      8'b0000_0000: return `CSTAT_CAT_GENERAL;
      8'b0000_001?: return `CSTAT_CAT_EXPER;
      8'b0001_????: return `CSTAT_CAT_SOLID;
      8'b0000_????: return `CSTAT_CAT_RSVD;
      8'b100?_????: return `CSTAT_CAT_LASER;
      8'b010?_????: return `CSTAT_CAT_DIGCONV;
      8'b110?_????: return `CSTAT_CAT_MAGNETIC;
      8'b001?_????: return `CSTAT_CAT_BCVIDEO;
      8'b0111_????: return `CSTAT_CAT_BCNOVID;
      8'b0110_0???: return `CSTAT_CAT_ADCNOCP;
      8'b0110_1???: return `CSTAT_CAT_ADCCP;
      8'b101?_????: return `CSTAT_CAT_MUSIC;
      default: return `CSTAT_CAT_RSVD;
    endcase
  endfunction
  function automatic logic [2:0] smpOf(input logic [2:0] s, input logic np);
    if (np) return (s == 3'h0) ? `CSTAT_SMP_NPCMDEF : `CSTAT_SMP_RSVD;
    if (s > 3'h3) return `CSTAT_SMP_RSVD;
    return s[1] ? `CSTAT_SMP_RSVEMPH : (s[0] ? `CSTAT_SMP_EMPH5015 : `CSTAT_SMP_NOEMPH);
  endfunction
  function automatic logic [31:0] decOf(input logic [23:0] sb, input logic lk, input logic tm);
    return {13'h0, tm ? 2'h2 : {1'b0, lk}, sb[19:16], 1'b0, sb[23:20], sb[7:6] == 2'h0,
      smpOf(sb[5:3], sb[1]), catOf(sb[15:8])};
  endfunction
  task automatic irqStep(input logic [7:0] a, input logic [31:0] v, input logic [31:0] st, input logic lvl);
    logic [31:0] d;
    logic [1:0] r;
    wr(a, v, r);
    repeat (3) @(posedge clk);
    chk("irq", {31'h0, lvl}, {31'h0, irq});
    rd(`CSTAT_OFS_IRQSTAT, d, r);
    chk("irq status", st, d);
  endtask
  task automatic results;
    $display("errors %0d checks %0d", errCount, checked);
    if (errCount == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [23:0] sb;
    d = $urandom(32'h461a);
    rst_b = 1'b0;
    statusBits = 24'h00_0000;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, loopLockedIn, oscTimeoutIn} = 7'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    // every category code, with mode, sampling and format walked alongside
    for (int i = 0; i < 256; i++) begin
      sb = 24'($urandom);
      sb[15:8] = i[7:0];
      {sb[7:6], sb[1], sb[5:3]} = {i[5:4], i[3], i[2:0]};
      statusBits <= sb;
      loopLockedIn <= 1'($urandom);
      oscTimeoutIn <= 1'($urandom);
      repeat (8) @(posedge clk);
      rd(`CSTAT_OFS_DECODE, d, r);
      chk("category", {28'h0, catOf(sb[15:8])}, {28'h0, d[3:0]});
      chk("decode", decOf(sb, loopLockedIn, oscTimeoutIn), d);
      rd(`CSTAT_OFS_LOOP, d, r);
      chk("loop", {23'h0, loopLockedIn, 3'h0, oscTimeoutIn, 4'h0}, d);
      rd(`CSTAT_OFS_CSLO, d, r);
      chk("raw", {8'h0, sb & 24'hFF_FFFA}, d);
    end
    wr(`CSTAT_OFS_LOOP, 32'hFFFF_FFFF, r);
    chk("loop write resp", {30'h0, `CSTAT_AXI_OKAY}, {30'h0, r});
    rd(`CSTAT_OFS_LOOP, d, r);
    chk("loop read resp", {30'h0, `CSTAT_AXI_OKAY}, {30'h0, r});
    chk("loop after write", {23'h0, loopLockedIn, 3'h0, oscTimeoutIn, 4'h0}, d);
    rd(8'h40, d, r);
    chk("unmapped read", {30'h0, `CSTAT_AXI_SLVERR}, {d[29:0], r});
    wr(8'h44, 32'h0, r);
    chk("unmapped write", {30'h0, `CSTAT_AXI_SLVERR}, {30'h0, r});
    loopLockedIn <= 1'b0;
    oscTimeoutIn <= 1'b0;
    repeat (8) @(posedge clk);
    wr(`CSTAT_OFS_IRQEN, 32'h0, r);
    irqStep(`CSTAT_OFS_IRQCLR, 32'h0000_0007, 32'h0, 1'b0);
    loopLockedIn <= 1'b1;
    repeat (8) @(posedge clk);
    // masked: status must latch while the output stays quiet
    irqStep(`CSTAT_OFS_IRQEN, 32'h0, 32'h0000_0001, 1'b0);
    irqStep(`CSTAT_OFS_IRQEN, 32'h0000_0007, 32'h0000_0001, 1'b1);
    rd(`CSTAT_OFS_IRQEN, d, r);
    chk("irq enable", 32'h0000_0007, d);
    irqStep(`CSTAT_OFS_IRQCLR, 32'h0000_0001, 32'h0, 1'b0);
    oscTimeoutIn <= 1'b1;
    statusBits <= ~statusBits;
    repeat (8) @(posedge clk);
    irqStep(`CSTAT_OFS_IRQEN, 32'h0000_0007, 32'h0000_0007, 1'b1);
    irqStep(`CSTAT_OFS_IRQEN, 32'h0, 32'h0000_0007, 1'b0);
    results;
  end
  initial begin
    #(20000 * 40);
    errCount++;
    results;
  end
endmodule // cstat_readout_bench
`default_nettype wire
